// file: verilog/abce_exec.sv
/*
  decode and execute unit: add, and, bit ops, skips, calls, table timing
  assumes: program memory answers INSTR_I for PROG_ADDR_O when valid,
  the file register reads asynchronously and writes at the clock edge
*/
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps

// How it works
// - add literal into working register, four flags
// - add register, d picks destination
// - add register plus carry, d picks destination
// - and literal into working register, zero only
// - and register, d picks destination, zero only
// - clear chosen bit of f, no flags
// - set chosen bit of f, no flags
// - skip next when chosen bit clear
// - skip next when chosen bit set
// - skip discards fetched word, runs nop
// - toggle chosen bit of f, no flags
// - call pushes pc plus one, loads literal
// - call updates pc high latch fields
// - long call loads latch and literal
// - internal table write waits for event
// - table read to pc low: three cycles
// - store-select: file only, or both
module abce_exec #(
  parameter logic [7:0] PCL_ADDR = 8'h02    // file address of pc_low_byte
) (
  input  wire logic        REF_CLK_I,       // 250 mhz clock
  input  wire logic        RST_B_I,         // synchronous reset, low
  input  wire logic        PSEL_I,          // apb select
  input  wire logic        PENABLE_I,       // apb access phase
  input  wire logic        PWRITE_I,        // apb direction
  input  wire logic [7:0]  PADDR_I,         // apb byte address
  input  wire logic [31:0] PWDATA_I,        // apb write data
  output logic      [31:0] PRDATA_O,        // apb read data
  output logic             PREADY_O,        // apb ready
  output logic             PSLVERR_O,       // apb error
  input  wire logic [15:0] INSTR_I,         // program word
  input  wire logic        INSTR_VALID_I,   // program word valid
  output logic             FETCH_O,         // word taken this cycle
  output logic      [15:0] PROG_ADDR_O,     // program counter
  output logic      [7:0]  FILE_ADDR_O,     // file read address
  input  wire logic [7:0]  FILE_RDATA_I,    // file read data
  output logic             FILE_WE_O,       // file write strobe
  output logic      [7:0]  FILE_WADDR_O,    // file write address
  output logic      [7:0]  FILE_WDATA_O,    // file write data
  output logic             STACK_PUSH_O,    // push return address
  output logic      [15:0] STACK_DATA_O,    // return address
  input  wire logic        TBL_INTERNAL_I,  // table pointer on internal memory
  input  wire logic        IRQ_EVENT_I      // interrupt event
);

  // ==========================================================
  // state
  abce_pkg::abce_state_type state_reg, state_next;
  logic [15:0] instr_reg;                   // word in execution
  logic        exec_valid_reg;              // word is not a nop
  logic        skip_pend_reg;               // skip waits for next fetch
  logic [1:0]  stall_cnt_reg;               // stall cycles left
  logic [15:0] pc_reg, pc_next;             // program counter
  logic [7:0]  work_reg, work_next;         // working_register
  logic [3:0]  status_reg, status_next;     // flags
  logic [7:0]  latch_reg, latch_next;       // pc_high_latch
  logic        file_we_reg;                 // file write pending
  logic [7:0]  file_waddr_reg;              // its address
  logic [7:0]  file_wdata_reg;              // its data
  logic        push_reg;                    // stack push strobe
  logic [15:0] push_data_reg;               // stack word
  logic [31:0] prdata_reg;                  // apb read data

  // ==========================================================
  // helpers
  // write targets {working, file} for d-form and s-form words
  function automatic logic [1:0] dest_sel(input logic is_s, input logic sel);
    if (is_s) begin
      dest_sel = sel ? 2'b01 : 2'b11;       // s-form
    end else begin
      dest_sel = sel ? 2'b01 : 2'b10;       // d-form
    end
  endfunction

  // ==========================================================
  // decode
  wire [7:0] lit     = instr_reg[7:0];      // literal or file address
  wire [2:0] bsel    = instr_reg[10:8];     // bit number
  wire       run     = (state_reg == abce_pkg::ST_RUN);
  wire       exec    = run && exec_valid_reg;
  wire       add_lit = instr_reg[15:8] == abce_pkg::OP_ADD_LIT;
  wire       and_lit = instr_reg[15:8] == abce_pkg::OP_AND_LIT;
  wire       long_call_op   = instr_reg[15:8] == abce_pkg::OP_LONG_CALL_OP;
  wire       add_reg = instr_reg[15:9] == abce_pkg::OP_ADD_REG;
  wire       add_c   = instr_reg[15:9] == abce_pkg::OP_ADD_C;
  wire       and_reg = instr_reg[15:9] == abce_pkg::OP_AND_REG;
  wire       clr_f   = instr_reg[15:9] == abce_pkg::OP_CLEAR_F;
  wire       tbl_rd  = instr_reg[15:10] == abce_pkg::OP_TBL_RD;
  wire       tbl_wr  = instr_reg[15:10] == abce_pkg::OP_TBL_WR;
  wire       bit_clr = instr_reg[15:11] == abce_pkg::OP_BIT_CLR;
  wire       bit_set = instr_reg[15:11] == abce_pkg::OP_BIT_SET;
  wire       sk_clr  = instr_reg[15:11] == abce_pkg::OP_SKIP_CLR;
  wire       sk_set  = instr_reg[15:11] == abce_pkg::OP_SKIP_SET;
  wire       bit_tog = instr_reg[15:11] == abce_pkg::OP_BIT_TOG;
  wire       call    = instr_reg[15:13] == abce_pkg::OP_CALL;
  wire       arith   = add_lit || add_reg || add_c;
  wire       logic_op = and_lit || and_reg;
  wire       d_form  = add_reg || add_c || and_reg;
  wire       bit_op  = bit_clr || bit_set || bit_tog;

  // ==========================================================
  // operands, forwarding the write still in flight
  wire       fwd     = file_we_reg && (file_waddr_reg == lit);
  wire [7:0] f_op    = fwd ? file_wdata_reg : FILE_RDATA_I;
  wire [7:0] bmask   = 8'h01 << bsel;
  wire       bit_val = f_op[bsel];
  wire [7:0] alu_b   = (add_lit || and_lit) ? lit : f_op;
  // carry joins the sum only for add with carry
  wire       alu_cin = add_c && status_reg[abce_pkg::STAT_C];
  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_dc;
  wire       alu_ov;
  wire       alu_z;

  abce_alu #(
    .WIDTH(8)
  ) u_alu (
    .a_i  (work_reg),
    .b_i  (alu_b),
    .cin_i(alu_cin),
    .and_i(logic_op),
    .res_o(alu_res),
    .c_o  (alu_c),
    .dc_o (alu_dc),
    .ov_o (alu_ov),
    .z_o  (alu_z)
  );

  // ==========================================================
  // result and write targets
  wire [7:0] bit_res = bit_clr ? (f_op & ~bmask) :
                       bit_set ? (f_op | bmask) :
                       (f_op ^ bmask);
  wire [7:0] result  = clr_f ? 8'h00 : bit_op ? bit_res : alu_res;
  wire [1:0] dsel    = dest_sel(clr_f, instr_reg[8]);
  // literal forms always land in the working register
  wire       wr_work = exec && (add_lit || and_lit ||
                                ((d_form || clr_f) && dsel[1]));
  // bit ops write back to f, flags untouched
  wire       wr_file = exec && (bit_op || ((d_form || clr_f) && dsel[0]));

  // ==========================================================
  // skips, branches and table timing
  // skip on the tested bit
  wire       skip    = exec && ((sk_clr && !bit_val) || (sk_set && bit_val));
  wire       branch  = exec && (call || long_call_op);
  wire       tbl     = exec && (tbl_rd || tbl_wr);
  wire       tbl_pcl = tbl_rd && (lit == PCL_ADDR);
  wire       fetch   = run && INSTR_VALID_I;
  // in-page call target keeps pc bits 15:13, takes 12:0 from the word
  wire [15:0] call_pc  = {pc_reg[15:13], instr_reg[12:0]};
  // latch forms the high byte of a long call
  wire [15:0] long_call_op_pc = {latch_reg, lit};
  wire [15:0] pc_inc   = pc_reg + 16'h0001;

  // ==========================================================
  // apb decode
  wire apb_setup = PSEL_I && !PENABLE_I;
  wire apb_wr    = PSEL_I && PENABLE_I && PWRITE_I;
  wire hit_work  = PADDR_I == abce_pkg::ADDR_WORK;
  wire hit_stat  = PADDR_I == abce_pkg::ADDR_STATUS;
  wire hit_latch = PADDR_I == abce_pkg::ADDR_LATCH;
  wire hit_pc    = PADDR_I == abce_pkg::ADDR_PC;
  wire mapped    = hit_work || hit_stat || hit_latch || hit_pc;
  wire [31:0] rd_mux = hit_work  ? {24'h0, work_reg} :
                       hit_stat  ? {28'h0, status_reg} :
                       hit_latch ? {24'h0, latch_reg} :
                       hit_pc    ? {16'h0, pc_reg} : 32'h0;

  // ==========================================================
  // next values; the executing word wins over a bus write
  always_comb begin
    work_next   = work_reg;
    status_next = status_reg;
    latch_next  = latch_reg;
    if (apb_wr && hit_work) begin
      work_next = PWDATA_I[7:0];
    end
    if (apb_wr && hit_stat) begin
      status_next = PWDATA_I[3:0];
    end
    if (apb_wr && hit_latch) begin
      latch_next = PWDATA_I[7:0];
    end
    if (wr_work) begin
      work_next = result;
    end
    if (exec && arith) begin
      // all four flags
      status_next[abce_pkg::STAT_C]  = alu_c;
      status_next[abce_pkg::STAT_DC] = alu_dc;
      status_next[abce_pkg::STAT_OV] = alu_ov;
      status_next[abce_pkg::STAT_Z]  = alu_z;
    end else if (exec && logic_op) begin
      status_next[abce_pkg::STAT_Z] = alu_z; // zero only
    end
    if (exec && call) begin
      latch_next = {pc_reg[15:13], instr_reg[12:8]};
    end
  end

  // program counter: branch, then fetch
  always_comb begin
    if (exec && call) begin
      pc_next = call_pc;
    end else if (exec && long_call_op) begin
      pc_next = long_call_op_pc;
    end else if (fetch) begin
      pc_next = pc_inc;
    end else begin
      pc_next = pc_reg;
    end
  end

  // sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      abce_pkg::ST_RUN: begin
        if (tbl && tbl_wr && TBL_INTERNAL_I) begin
          state_next = abce_pkg::ST_TBL_PROG;
        end else if (tbl) begin
          state_next = abce_pkg::ST_STALL;
        end
      end
      abce_pkg::ST_STALL: begin
        if (stall_cnt_reg == 2'h1) begin
          state_next = abce_pkg::ST_RUN;
        end
      end
      abce_pkg::ST_TBL_PROG: begin
        if (IRQ_EVENT_I) begin
          state_next = abce_pkg::ST_RUN;      // event ends it
        end
      end
    endcase
  end

  // ==========================================================
  // pipeline registers
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      state_reg      <= abce_pkg::ST_RUN;
      instr_reg      <= 16'h0000;
      exec_valid_reg <= 1'b0;
      skip_pend_reg  <= 1'b0;
      stall_cnt_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (fetch) begin
        instr_reg <= INSTR_I;
      end
      if (fetch) begin
        // fetched word dropped after a skip or branch
        exec_valid_reg <= !(skip || branch || skip_pend_reg);
      end else if (run) begin
        exec_valid_reg <= 1'b0;
      end
      if (fetch) begin
        skip_pend_reg <= 1'b0;
      end else if (skip) begin
        skip_pend_reg <= 1'b1;
      end
      if (tbl) begin
        stall_cnt_reg <= tbl_pcl ? abce_pkg::STALL_TBL_PCL : abce_pkg::STALL_TBL;
      end else if (state_reg == abce_pkg::ST_STALL) begin
        stall_cnt_reg <= stall_cnt_reg - 2'h1;
      end
    end
  end

  // architectural registers
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      pc_reg     <= abce_pkg::RST_PC;
      work_reg   <= abce_pkg::RST_WORK;
      status_reg <= abce_pkg::RST_STATUS;
      latch_reg  <= abce_pkg::RST_LATCH;
    end else begin
      pc_reg     <= pc_next;
      work_reg   <= work_next;
      status_reg <= status_next;
      latch_reg  <= latch_next;
    end
  end

  // file write port, stack push, bus read data
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
      file_we_reg    <= 1'b0;
      file_waddr_reg <= 8'h00;
      file_wdata_reg <= 8'h00;
      push_reg       <= 1'b0;
      push_data_reg  <= 16'h0000;
      prdata_reg     <= 32'h0000_0000;
    end else begin
      file_we_reg    <= wr_file;
      file_waddr_reg <= lit;
      file_wdata_reg <= result;
      push_reg       <= branch;
      push_data_reg  <= pc_reg;
      if (apb_setup) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // ==========================================================
  // outputs
  assign FETCH_O      = fetch;
  assign PROG_ADDR_O  = pc_reg;
  assign FILE_ADDR_O  = lit;
  assign FILE_WE_O    = file_we_reg;
  assign FILE_WADDR_O = file_waddr_reg;
  assign FILE_WDATA_O = file_wdata_reg;
  assign STACK_PUSH_O = push_reg;
  assign STACK_DATA_O = push_data_reg;
  assign PRDATA_O     = prdata_reg;
  assign PREADY_O     = 1'b1;
  assign PSLVERR_O    = PSEL_I && PENABLE_I && !mapped;

  // ==========================================================
  // checks
  sequence tbl_pcl_seq;
    !FETCH_O ##1 !FETCH_O;
  endsequence

  add_literal_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    exec && add_lit |=> work_reg == 8'($past(work_reg) + $past(lit)))
    else $error("add literal result wrong");

  add_dest_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    exec && add_reg && instr_reg[8] |=> FILE_WE_O && $stable(work_reg))
    else $error("add register destination wrong");

  and_literal_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    exec && and_lit |=> work_reg == ($past(work_reg) & $past(lit))
      && status_reg[abce_pkg::STAT_C] == $past(status_reg[abce_pkg::STAT_C]))
    else $error("and literal wrong");

  zero_flag_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    exec && logic_op |=> status_reg[abce_pkg::STAT_Z] ==
      (($past(work_reg) & $past(alu_b)) == 8'h00))
    else $error("zero flag wrong");

  bit_clear_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    exec && bit_clr |=> FILE_WE_O && !FILE_WDATA_O[$past(bsel)] && $stable(status_reg))
    else $error("bit clear wrong");

  bit_set_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    exec && bit_set |=> FILE_WE_O && FILE_WDATA_O[$past(bsel)] && $stable(status_reg))
    else $error("bit set wrong");

  skip_nop_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    skip && fetch |=> !exec_valid_reg)
    else $error("skipped word executed");

  call_push_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    exec && call |=> STACK_PUSH_O && STACK_DATA_O == $past(pc_reg)
      && PROG_ADDR_O[12:0] == $past(instr_reg[12:0]))
    else $error("call push or target wrong");

  call_latch_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    exec && call |=> latch_reg == {$past(pc_reg[15:13]), $past(instr_reg[12:8])})
    else $error("pc high latch wrong");

  long_call_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    exec && long_call_op |=> PROG_ADDR_O == {$past(latch_reg), $past(lit)})
    else $error("long call target wrong");

  tbl_read_pcl_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    tbl && tbl_pcl |=> tbl_pcl_seq ##1 run)
    else $error("table read to pc low not three cycles");

  tbl_prog_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    state_reg == abce_pkg::ST_TBL_PROG && !IRQ_EVENT_I |=> !FETCH_O && !run)
    else $error("internal table write ended early");

endmodule

// file: verilog/abce_pkg.sv
/*
  constants, opcode patterns and types shared by the execution unit
  assumes: a 16-bit instruction word and an 8-bit data path
*/
package abce_pkg;

  // ==========================================================
  // register offsets on the apb bus (byte addresses)
  localparam logic [7:0] ADDR_WORK   = 8'h00; // working_register
  localparam logic [7:0] ADDR_STATUS = 8'h04; // arithmetic flags
  localparam logic [7:0] ADDR_LATCH  = 8'h08; // pc_high_latch
  localparam logic [7:0] ADDR_PC     = 8'h0c; // program counter, read only

  // ==========================================================
  // status field positions
  localparam int STAT_C  = 0;               // carry
  localparam int STAT_DC = 1;               // digit_carry_flag
  localparam int STAT_Z  = 2;               // zero
  localparam int STAT_OV = 3;               // overflow_flag

  // ==========================================================
  // values after reset
  localparam logic [7:0]  RST_WORK   = 8'h00;
  localparam logic [3:0]  RST_STATUS = 4'h0;
  localparam logic [7:0]  RST_LATCH  = 8'h00;
  localparam logic [15:0] RST_PC     = 16'h0000;

  // ==========================================================
  // opcode patterns, compared against the top bits of the word
  localparam logic [7:0] OP_ADD_LIT  = 8'hb1; // add_literal_op
  localparam logic [7:0] OP_AND_LIT  = 8'hb5; // and_literal_op
  localparam logic [7:0] OP_LONG_CALL_OP    = 8'hb7; // long_call_op
  localparam logic [6:0] OP_ADD_REG  = 7'h07; // add_register_op
  localparam logic [6:0] OP_ADD_C    = 7'h08; // add_with_carry_op
  localparam logic [6:0] OP_AND_REG  = 7'h05; // and_register_op
  localparam logic [6:0] OP_CLEAR_F  = 7'h14; // clear f, store-select form
  localparam logic [5:0] OP_TBL_RD   = 6'h2a; // table_read_op
  localparam logic [5:0] OP_TBL_WR   = 6'h2b; // table write
  localparam logic [4:0] OP_BIT_CLR  = 5'h11; // bit_clear_op
  localparam logic [4:0] OP_BIT_SET  = 5'h10; // bit_set_op
  localparam logic [4:0] OP_SKIP_CLR = 5'h13; // skip_if_clear_op
  localparam logic [4:0] OP_SKIP_SET = 5'h12; // skip_if_set_op
  localparam logic [4:0] OP_BIT_TOG  = 5'h07; // bit_toggle_op
  localparam logic [2:0] OP_CALL     = 3'h7;  // in-page call

  // ==========================================================
  // extra cycles that table transfers hold the pipeline
  localparam logic [1:0] STALL_TBL     = 2'h1; // two cycles in all
  localparam logic [1:0] STALL_TBL_PCL = 2'h2; // three cycles in all

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_RUN,                                  // fetch and execute
    ST_STALL,                                // counted table stall
    ST_TBL_PROG                              // internal write, wait for event
  } abce_state_type;

endpackage

// file: verilog/abce_alu.sv
/*
  8-bit adder and and-unit with carry, digit carry, overflow, zero
  assumes: purely combinational, operands stable during the cycle
*/
`timescale 1ns/1ps

module abce_alu #(
  parameter int WIDTH = 8                   // data path width
) (
  input  wire logic [WIDTH-1:0] a_i,        // working_register
  input  wire logic [WIDTH-1:0] b_i,        // literal or file operand
  input  wire logic             cin_i,      // carry into the sum
  input  wire logic             and_i,      // high: and, low: add
  output logic      [WIDTH-1:0] res_o,      // result
  output logic                  c_o,        // carry out of the top bit
  output logic                  dc_o,       // carry out of the low nibble
  output logic                  ov_o,       // two's complement overflow
  output logic                  z_o         // result is zero
);

  // ==========================================================
  // sums
  logic [WIDTH:0] sum_full;                 // sum with carry out
  logic [4:0]     sum_nib;                  // low nibble sum

  assign sum_full = {1'b0, a_i} + {1'b0, b_i} + {{WIDTH{1'b0}}, cin_i};
  assign sum_nib  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};

  // ==========================================================
  // result and flags
  // select and or sum
  assign res_o = and_i ? (a_i & b_i) : sum_full[WIDTH-1:0];
  assign c_o   = sum_full[WIDTH];
  assign dc_o  = sum_nib[4];
  // same signs in, other sign out
  assign ov_o  = (a_i[WIDTH-1] == b_i[WIDTH-1]) &&
                 (sum_full[WIDTH-1] != a_i[WIDTH-1]);
  // zero only on an all-zero result
  assign z_o   = (res_o == '0);

endmodule

// file: verification/abce_prog_model.sv
/* program memory, data register file and stack capture for abce_exec
   assumes: words read at the program counter, file writes at the edge */
`timescale 1ns/1ps
module abce_prog_model (
  input  wire logic        clk_i,    // core clock
  input  wire logic        run_i,    // words offered
  input  wire logic [15:0] addr_i,   // program counter
  output logic      [15:0] instr_o,  // program word
  output logic             valid_o,  // word valid
  input  wire logic [7:0]  raddr_i,  // file read address
  output logic      [7:0]  rdata_o,  // file read data
  input  wire logic        we_i,     // file write strobe
  input  wire logic [7:0]  waddr_i,  // file write address
  input  wire logic [7:0]  wdata_i,  // file write data
  input  wire logic        push_i,   // stack push
  input  wire logic [15:0] pdata_i   // return address
);
  // ==========================================================
  // storage
  logic [15:0] prog [0:65535];  // program words
  logic [7:0]  regs [0:255];    // data register file
  logic [15:0] pushes [$];      // stack_top history
  // an idle bus shows the inverse word, never a stale one
  assign valid_o = run_i;
  assign instr_o = run_i ? prog[addr_i] : ~prog[addr_i];
  assign rdata_o = regs[raddr_i];
  // file write and push land at the edge after the strobe
  always @(posedge clk_i) begin
    if (we_i) begin
      regs[waddr_i] <= wdata_i;
    end
    if (push_i) begin
      pushes.push_back(pdata_i);
    end
  end
endmodule

// file: verification/abce_exec_bench.sv
/* self-checking bench for abce_exec: runs one program, checks results
   assumes: abce_pkg compiled first, model in abce_prog_model */
`timescale 1ns/1ps
module arith_bit_call_exec_bench;
  logic        clk, rst_b, psel, penable, pwrite, run, err, we, push;
  logic [7:0]  paddr, faddr, frd, fwa, fwd;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] instr, pc, sdata;
  logic        valid, ready, slverr;
  int          n_mismatch, checked, cyc;
  // ==========================================================
  // program: add, and, bit ops, skips, call, long call
  localparam logic [15:0] LOW [14] = '{16'hb115, 16'h0f10, 16'h0a11, 16'h8f11,
    16'h8412, 16'h3b12, 16'h9912, 16'hb501, 16'h9112, 16'hb180, 16'h0f14,
    16'hb500, 16'hf020, 16'hb110};
  localparam logic [15:0] HIGH [6] = '{16'hb1ff, 16'hb101, 16'h1013, 16'hb17d,
    16'hb740, 16'hb101};
  abce_exec uut (.REF_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(ready), .PSLVERR_O(slverr), .INSTR_I(instr), .INSTR_VALID_I(valid),
    .FETCH_O(), .PROG_ADDR_O(pc), .FILE_ADDR_O(faddr), .FILE_RDATA_I(frd),
    .FILE_WE_O(we), .FILE_WADDR_O(fwa), .FILE_WDATA_O(fwd), .STACK_PUSH_O(push),
    .STACK_DATA_O(sdata), .TBL_INTERNAL_I(1'b0), .IRQ_EVENT_I(1'b0));
  abce_prog_model pm (.clk_i(clk), .run_i(run), .addr_i(pc), .instr_o(instr),
    .valid_o(valid), .raddr_i(faddr), .rdata_o(frd), .we_i(we), .waddr_i(fwa),
    .wdata_i(fwd), .push_i(push), .pdata_i(sdata));
  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = slverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_bus();
    apb(1'b0, abce_pkg::ADDR_PC, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, abce_pkg::ADDR_WORK, 32'h10);
  endtask
  // runs the program until the long-call target has executed
  task automatic t_run();
    for (int i = 0; i < 14; i++) pm.prog[i] = LOW[i];
    for (int i = 0; i < 6; i++) pm.prog[16'h1020 + i] = HIGH[i];
    pm.prog[16'h1040] = 16'h0f15;
    @(posedge clk);
    run <= 1'b1;
    for (int i = 0; i < 200 && pc !== 16'h1044; i++) @(posedge clk);
    run <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_results();
    chk(pm.regs[8'h10], 8'he7);
    chk(pm.regs[8'h11], 8'h47);
    chk(pm.regs[8'h12], 8'h12);
    chk(pm.regs[8'h14], 8'h01);
    chk(pm.regs[8'h15], 8'h80);
    chk(pm.pushes[0], 16'h000d);
    apb(1'b0, abce_pkg::ADDR_WORK, 32'h0);
    chk(rd, 32'h80);
    apb(1'b0, abce_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, abce_pkg::ADDR_LATCH, 32'h0);
    chk(rd, 32'h10);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {rst_b, psel, penable, pwrite, run, paddr, pwdata} = '0;
    n_mismatch = 0;
    checked = 0;
    cyc = 0;
    for (int i = 0; i < 65536; i++) pm.prog[i] = 16'h0000;
    for (int i = 0; i < 256; i++) pm.regs[i] = 8'h00;
    pm.regs[8'h10] = 8'hc2;
    pm.regs[8'h11] = 8'hc7;
    pm.regs[8'h12] = 8'h0a;
    pm.regs[8'h13] = 8'h02;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_bus();
    t_run();
    t_results();
    close_out();
  end
endmodule
